// ---- pkg/tmo_pkg.sv ----
// tmo_pkg: register map, field positions and reset values for the timer
// option and interrupt register block.
// assumes a 32-bit register port that decodes the full byte addresses below.
package tmo_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // register byte addresses
    localparam logic [31:0] ADDR_T1_PENDING = 32'h4000a800;
    localparam logic [31:0] ADDR_T2_PENDING = 32'h4000a804;
    localparam logic [31:0] ADDR_T1_MISSED = 32'h4000a818;
    localparam logic [31:0] ADDR_T2_MISSED = 32'h4000a81c;
    localparam logic [31:0] ADDR_T1_ENABLE = 32'h4000a840;
    localparam logic [31:0] ADDR_T2_ENABLE = 32'h4000a844;
    localparam logic [31:0] ADDR_T1_OPTIONS = 32'h4000e050;
    localparam logic [31:0] ADDR_T2_OPTIONS = 32'h4000f050;
    // block-level interrupt status and mask
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'h4000a880;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'h4000a884;

    // option register fields
    localparam int OPT_TRIG_LSB = 0;
    localparam int OPT_GATE_EN = 2;
    localparam int OPT_RSVD = 3;
    localparam int OPT_REMAP_LSB = 4;
    localparam logic [7:0] OPT1_MASK = 8'h0f;
    localparam logic [7:0] OPT2_MASK = 8'hff;

    // trigger source codes
    localparam logic [1:0] TRIG_PCLK = 2'h0;
    localparam logic [1:0] TRIG_1KHZ = 2'h1;
    localparam logic [1:0] TRIG_32KHZ = 2'h2;
    localparam logic [1:0] TRIG_PIN = 2'h3;

    // interrupt flag/enable layout
    localparam int IRQ_UPDATE = 0;
    localparam int IRQ_CHAN_LSB = 1;
    localparam int IRQ_TRIGGER = 6;
    localparam logic [6:0] IRQ_MASK = 7'h5f;
    localparam int MISS_LSB = 9;
    localparam int PEND_RSVD_LSB = 9;

    // status register layout: bit 0 timer1, bit 1 timer2 missed events
    localparam int STAT_T1_MISS = 0;
    localparam int STAT_T2_MISS = 1;

    localparam logic [31:0] RESET_VALUE = 32'h0;

endpackage

// ---- rtl/tmo_timer_irq.sv ----
// tmo_timer_irq: pending and missed flags for one timer.
// assumes events are one-cycle pulses on clk_sys, reset already synced.
`timescale 1ns/1ps
`default_nettype none
module tmo_timer_irq (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // timer events: [6] trigger, [4:1] channels, [0] update
    input wire logic [6:0] event_in,
    // software write-one-to-clear for pending; missed flags take the written value
    input wire logic [6:0] pend_clr,
    input wire logic [3:0] miss_wr,
    input wire logic miss_we,
    // state
    output logic [6:0] pend_q,
    output logic [3:0] miss_q,
    output logic miss_event
);

    logic [6:0] pend_d;
    logic [3:0] miss_d;
    logic [3:0] chan_ev;
    logic [3:0] chan_pend;

    always_comb begin
        chan_ev = event_in[4:1];
        chan_pend = pend_q[4:1];
        // set wins over clear so no event is lost
        pend_d = ((pend_q & ~pend_clr) | event_in) & tmo_pkg::IRQ_MASK;
        miss_d = miss_we ? miss_wr : miss_q;
        // recurrence while still pending marks a miss
        miss_d = miss_d | (chan_ev & chan_pend);
        miss_event = |(chan_ev & chan_pend);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= '0;
            miss_q <= '0;
        end else begin
            pend_q <= pend_d;
            miss_q <= miss_d;
        end
    end

    chk_miss_sets: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (event_in[1] && pend_q[1]) |=> miss_q[0])
        else $error("missed bit not set on recurring event");
    chk_pend_sets: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        event_in[0] |=> pend_q[0])
        else $error("pending flag not set by event");

endmodule
`default_nettype wire

// ---- rtl/tmo_regs.sv ----
// tmo_regs: option, interrupt enable, pending and missed registers for
// two timers, with trigger select, clock gating and second timer channel pin remap.
// assumes timer events are clk_sys pulses; pins and slow clocks are async.
`timescale 1ns/1ps
`default_nettype none
module tmo_regs (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // register port
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // trigger sources
    input wire logic cal_1khz_clk,
    input wire logic ref_32khz_clk,
    input wire logic first_timer_ext_clock_pin,
    input wire logic second_timer_ext_clock_pin,
    input wire logic first_timer_gate_input,
    input wire logic second_timer_gate_input,
    // selected external triggers, synchronised level
    output logic t1_trigger,
    output logic t2_trigger,
    // timer events
    input wire logic [6:0] t1_events,
    input wire logic [6:0] t2_events,
    // second timer channel pin routing, 1 = port B
    output logic [3:0] chan_pin_remap,
    // interrupts
    output logic t1_irq,
    output logic t2_irq,
    output logic irq
);

    logic rst_s1_q, rst_n;
    logic [5:0] sync1_q, sync2_q;
    logic [7:0] opt1_q, opt1_d, opt2_q, opt2_d;
    logic [6:0] en1_q, en1_d, en2_q, en2_d;
    logic [1:0] stat_q, stat_d, mask_q, mask_d;
    logic [31:0] rdata_q, rdata_d;
    logic t1_trig_q, t1_trig_d, t2_trig_q, t2_trig_d;
    logic t1_irq_q, t1_irq_d, t2_irq_q, t2_irq_d, irq_q, irq_d;
    logic [3:0] remap_q, remap_d;
    logic [6:0] pend1, pend2, clr1, clr2;
    logic [3:0] miss1, miss2;
    logic miss1_ev, miss2_ev, we_miss1, we_miss2;

    function automatic logic sel_trig(input logic [7:0] opt,
                                      input logic [5:0] src, input int pin,
                                      input int gate);
        logic clk_in;
        clk_in = src[pin];
        // gate input only counts while gating is enabled
        if (opt[tmo_pkg::OPT_GATE_EN])
            clk_in = clk_in & src[gate];
        // source pick by two-bit code
        case (opt[tmo_pkg::OPT_TRIG_LSB +: 2])
            tmo_pkg::TRIG_PCLK: sel_trig = 1'b1;
            tmo_pkg::TRIG_1KHZ: sel_trig = src[0];
            tmo_pkg::TRIG_32KHZ: sel_trig = src[1];
            default: sel_trig = clk_in;
        endcase
    endfunction

    // reset release through two flops
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // async sources pass two flops before use
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {second_timer_gate_input, first_timer_gate_input,
                        second_timer_ext_clock_pin,
                        first_timer_ext_clock_pin,
                        ref_32khz_clk, cal_1khz_clk};
            sync2_q <= sync1_q;
        end
    end

    always_comb begin
        // write-one-to-clear strobes for pending flags
        clr1 = (wr && addr == tmo_pkg::ADDR_T1_PENDING) ? wdata[6:0] : '0;
        clr2 = (wr && addr == tmo_pkg::ADDR_T2_PENDING) ? wdata[6:0] : '0;
        we_miss1 = wr && addr == tmo_pkg::ADDR_T1_MISSED;
        we_miss2 = wr && addr == tmo_pkg::ADDR_T2_MISSED;
    end

    tmo_timer_irq u_irq1 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .event_in(t1_events),
        .pend_clr(clr1),
        .miss_wr(wdata[tmo_pkg::MISS_LSB +: 4]),
        .miss_we(we_miss1),
        .pend_q(pend1),
        .miss_q(miss1),
        .miss_event(miss1_ev)
    );

    tmo_timer_irq u_irq2 (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .event_in(t2_events),
        .pend_clr(clr2),
        .miss_wr(wdata[tmo_pkg::MISS_LSB +: 4]),
        .miss_we(we_miss2),
        .pend_q(pend2),
        .miss_q(miss2),
        .miss_event(miss2_ev)
    );

    always_comb begin
        opt1_d = opt1_q;
        opt2_d = opt2_q;
        en1_d = en1_q;
        en2_d = en2_q;
        mask_d = mask_q;
        // bit 3 stored as written; software keeps it zero
        if (wr) begin
            case (addr)
                tmo_pkg::ADDR_T1_OPTIONS:
                    opt1_d = wdata[7:0] & tmo_pkg::OPT1_MASK;
                tmo_pkg::ADDR_T2_OPTIONS:
                    opt2_d = wdata[7:0] & tmo_pkg::OPT2_MASK;
                tmo_pkg::ADDR_T1_ENABLE:
                    en1_d = wdata[6:0] & tmo_pkg::IRQ_MASK;
                tmo_pkg::ADDR_T2_ENABLE:
                    en2_d = wdata[6:0] & tmo_pkg::IRQ_MASK;
                tmo_pkg::ADDR_IRQ_MASK: mask_d = wdata[1:0];
                default: ;
            endcase
        end
        // missed events are sticky; set wins over write-one-clear
        stat_d = stat_q;
        if (wr && addr == tmo_pkg::ADDR_IRQ_STATUS)
            stat_d = stat_q & ~wdata[1:0];
        stat_d[tmo_pkg::STAT_T1_MISS] =
            stat_d[tmo_pkg::STAT_T1_MISS] | miss1_ev;
        stat_d[tmo_pkg::STAT_T2_MISS] =
            stat_d[tmo_pkg::STAT_T2_MISS] | miss2_ev;
    end

    always_comb begin
        rdata_d = tmo_pkg::RESET_VALUE;
        // reserved fields read zero except option bit 3, which reads back as written; software must ignore them
        if (rd) begin
            case (addr)
                tmo_pkg::ADDR_T1_PENDING: rdata_d[6:0] = pend1;
                tmo_pkg::ADDR_T2_PENDING: rdata_d[6:0] = pend2;
                tmo_pkg::ADDR_T1_MISSED: rdata_d[12:9] = miss1;
                tmo_pkg::ADDR_T2_MISSED: rdata_d[12:9] = miss2;
                tmo_pkg::ADDR_T1_ENABLE: rdata_d[6:0] = en1_q;
                tmo_pkg::ADDR_T2_ENABLE: rdata_d[6:0] = en2_q;
                tmo_pkg::ADDR_T1_OPTIONS: rdata_d[7:0] = opt1_q;
                tmo_pkg::ADDR_T2_OPTIONS: rdata_d[7:0] = opt2_q;
                tmo_pkg::ADDR_IRQ_STATUS: rdata_d[1:0] = stat_q;
                tmo_pkg::ADDR_IRQ_MASK: rdata_d[1:0] = mask_q;
                default: rdata_d = tmo_pkg::RESET_VALUE;
            endcase
        end
    end

    always_comb begin
        t1_trig_d = sel_trig(opt1_q, sync2_q, 2, 4);
        t2_trig_d = sel_trig(opt2_q, sync2_q, 3, 5);
        remap_d = opt2_q[tmo_pkg::OPT_REMAP_LSB +: 4];
        // per-timer line: pending and enabled
        t1_irq_d = |(pend1 & en1_q);
        t2_irq_d = |(pend2 & en2_q);
        irq_d = |(stat_q & mask_q);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // everything clears on reset
            opt1_q <= '0;
            opt2_q <= '0;
            en1_q <= '0;
            en2_q <= '0;
            stat_q <= '0;
            mask_q <= '0;
            rdata_q <= '0;
            t1_trig_q <= 1'b0;
            t2_trig_q <= 1'b0;
            remap_q <= '0;
            t1_irq_q <= 1'b0;
            t2_irq_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            opt1_q <= opt1_d;
            opt2_q <= opt2_d;
            en1_q <= en1_d;
            en2_q <= en2_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
            t1_trig_q <= t1_trig_d;
            t2_trig_q <= t2_trig_d;
            remap_q <= remap_d;
            t1_irq_q <= t1_irq_d;
            t2_irq_q <= t2_irq_d;
            irq_q <= irq_d;
        end
    end

    assign rdata = rdata_q;
    assign t1_trigger = t1_trig_q;
    assign t2_trigger = t2_trig_q;
    assign chan_pin_remap = remap_q;
    assign t1_irq = t1_irq_q;
    assign t2_irq = t2_irq_q;
    assign irq = irq_q;

    sequence s_wr_opt2;
        wr && addr == tmo_pkg::ADDR_T2_OPTIONS;
    endsequence

    sequence s_rd_miss2;
        rd && addr == tmo_pkg::ADDR_T2_MISSED;
    endsequence

    // a same-cycle event would win, so only a quiet clear is checked
    sequence s_clr_pend1;
        wr && addr == tmo_pkg::ADDR_T1_PENDING && wdata[0] && !t1_events[0];
    endsequence

    chk_remap_follows: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_wr_opt2 |=> ##1 chan_pin_remap == $past(wdata[7:4], 2))
        else $error("channel remap does not follow option write");
    chk_pclk_trigger: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        opt1_q[1:0] == 2'h0 |=> t1_trigger)
        else $error("bus clock trigger not selected");
    chk_gate_t1: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (opt1_q[2:0] == 3'h7 && !sync2_q[4]) |=> !t1_trigger)
        else $error("first timer gate input ignored");
    chk_gate_t2: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (opt2_q[2:0] == 3'h3 && sync2_q[3]) |=> t2_trigger)
        else $error("second timer gate applied while disabled");
    chk_gate_t2_on: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (opt2_q[2:0] == 3'h7 && !sync2_q[5]) |=> !t2_trigger)
        else $error("second timer gate input ignored");
    chk_enable_rw: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (wr && addr == tmo_pkg::ADDR_T1_ENABLE) |=>
            en1_q == ($past(wdata[6:0]) & tmo_pkg::IRQ_MASK))
        else $error("enable register not written");
    chk_read_pending: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (rd && addr == tmo_pkg::ADDR_T1_PENDING) |=>
            rdata == {25'h0, $past(pend1)})
        else $error("pending read data wrong");
    chk_read_missed: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_rd_miss2 |=> rdata == {19'h0, $past(miss2), 9'h0})
        else $error("missed read data wrong");
    chk_read_unmapped: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (rd && addr == 32'h4000a808) |=> rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_pend_clear: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s_clr_pend1 |=> !pend1[0])
        else $error("pending flag not cleared by write");
    chk_irq_level: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (pend1[0] && en1_q[0]) |=> t1_irq)
        else $error("timer interrupt not raised");
    chk_irq_quiet: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !(|(pend2 & en2_q)) |=> !t2_irq)
        else $error("timer interrupt raised while disabled");
    chk_status_sets: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        miss2_ev |=> stat_q[tmo_pkg::STAT_T2_MISS])
        else $error("status bit not set on missed event");

endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// testbench: self-checking bench for the timer option and irq registers.
// assumes tmo_regs alone on one 50 MHz clock; the bench drives every port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys, nrst, wr, rd, cal_clk, ref_clk, pin1, pin2, gate1, gate2;
    logic [31:0] addr, wdata, rdata, rv;
    logic [6:0] ev1, ev2;
    logic [3:0] remap;
    logic trig1, trig2, t1_irq, t2_irq, irq;
    int fail_count, total_checks;

    tmo_regs i_tmo_regs (.clk_sys(clk_sys), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .cal_1khz_clk(cal_clk), .ref_32khz_clk(ref_clk),
        .first_timer_ext_clock_pin(pin1), .second_timer_ext_clock_pin(pin2),
        .first_timer_gate_input(gate1), .second_timer_gate_input(gate2),
        .t1_trigger(trig1), .t2_trigger(trig2), .t1_events(ev1),
        .t2_events(ev2), .chan_pin_remap(remap), .t1_irq(t1_irq),
        .t2_irq(t2_irq), .irq(irq));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        rd_reg(a, rv);
        check(rv, exp, "register read");
    endtask

    task automatic pulse(input logic [6:0] e1, input logic [6:0] e2);
        @(posedge clk_sys);
        ev1 <= e1;
        ev2 <= e2;
        @(posedge clk_sys);
        ev1 <= 7'h00;
        ev2 <= 7'h00;
    endtask

    // irq outputs are registered, so give them a few cycles to land
    task automatic settle();
        repeat (4) @(posedge clk_sys);
        #1;
    endtask

    task automatic test_reset();
        logic [31:0] regs [10] = '{tmo_pkg::ADDR_T1_PENDING,
            tmo_pkg::ADDR_T2_PENDING, tmo_pkg::ADDR_T1_MISSED,
            tmo_pkg::ADDR_T2_MISSED, tmo_pkg::ADDR_T1_ENABLE,
            tmo_pkg::ADDR_T2_ENABLE, tmo_pkg::ADDR_T1_OPTIONS,
            tmo_pkg::ADDR_T2_OPTIONS, tmo_pkg::ADDR_IRQ_STATUS,
            tmo_pkg::ADDR_IRQ_MASK};
        for (int i = 0; i < 10; i++) begin
            rd_chk(regs[i], 32'h0);
        end
        wr_reg(32'h4000a808, 32'hffffffff);
        rd_chk(32'h4000a808, 32'h0);
        check({28'h0, remap}, 32'h0, "remap after reset");
        check({29'h0, t1_irq, t2_irq, irq}, 32'h0, "irq after reset");
        $display("test reset finished");
    endtask

    task automatic test_options();
        wr_reg(tmo_pkg::ADDR_T1_OPTIONS, 32'hfffffff7);
        rd_chk(tmo_pkg::ADDR_T1_OPTIONS, 32'h00000007);
        wr_reg(tmo_pkg::ADDR_T2_OPTIONS, 32'hfffffff7);
        rd_chk(tmo_pkg::ADDR_T2_OPTIONS, 32'h000000f7);
        for (int i = 0; i < 4; i++) begin
            wr_reg(tmo_pkg::ADDR_T2_OPTIONS, 32'h10 << i);
            settle();
            check({28'h0, remap}, 32'h1 << i, "channel remap");
        end
        wr_reg(tmo_pkg::ADDR_T1_ENABLE, 32'hffffffff);
        wr_reg(tmo_pkg::ADDR_T2_ENABLE, 32'hffffffff);
        rd_chk(tmo_pkg::ADDR_T1_ENABLE, 32'h0000005f);
        rd_chk(tmo_pkg::ADDR_T2_ENABLE, 32'h0000005f);
        wr_reg(tmo_pkg::ADDR_T1_ENABLE, 32'h0);
        wr_reg(tmo_pkg::ADDR_T2_ENABLE, 32'h0);
        wr_reg(tmo_pkg::ADDR_T2_OPTIONS, 32'h0);
        $display("test options finished");
    endtask

    // 1 kHz and 32 kHz sources are set opposite so a swapped code shows
    task automatic trig_case(input logic [1:0] code, input logic g_en,
        input logic lvl, input logic g1, input logic g2);
        logic e1, e2;
        e1 = (code == 2'h0) ? 1'b1 : (code == 2'h1) ? lvl :
             (code == 2'h2) ? ~lvl : (lvl & (~g_en | g1));
        e2 = (code == 2'h3) ? (lvl & (~g_en | g2)) : e1;
        @(posedge clk_sys);
        cal_clk <= lvl;
        ref_clk <= ~lvl;
        pin1 <= lvl;
        pin2 <= lvl;
        gate1 <= g1;
        gate2 <= g2;
        wr_reg(tmo_pkg::ADDR_T1_OPTIONS, {29'h0, g_en, code});
        wr_reg(tmo_pkg::ADDR_T2_OPTIONS, {29'h0, g_en, code});
        settle();
        check({31'h0, trig1}, {31'h0, e1}, "first trigger");
        check({31'h0, trig2}, {31'h0, e2}, "second trigger");
    endtask

    task automatic test_trigger();
        for (int c = 0; c < 4; c++) begin
            trig_case(c[1:0], 1'b0, 1'b0, 1'b0, 1'b0);
            trig_case(c[1:0], 1'b0, 1'b1, 1'b0, 1'b0);
        end
        trig_case(2'h3, 1'b1, 1'b1, 1'b1, 1'b0);
        trig_case(2'h3, 1'b1, 1'b1, 1'b0, 1'b1);
        trig_case(2'h3, 1'b1, 1'b0, 1'b1, 1'b1);
        $display("test trigger finished");
    endtask

    task automatic test_pending();
        pulse(7'h7f, 7'h00);
        rd_chk(tmo_pkg::ADDR_T1_PENDING, 32'h0000005f);
        rd_chk(tmo_pkg::ADDR_T2_PENDING, 32'h0);
        check({31'h0, t1_irq}, 32'h0, "irq while disabled");
        wr_reg(tmo_pkg::ADDR_T1_ENABLE, 32'h00000001);
        settle();
        check({31'h0, t1_irq}, 32'h1, "irq when enabled");
        wr_reg(tmo_pkg::ADDR_T1_PENDING, 32'h00000001);
        rd_chk(tmo_pkg::ADDR_T1_PENDING, 32'h0000005e);
        settle();
        check({31'h0, t1_irq}, 32'h0, "irq after clear");
        pulse(7'h00, 7'h40);
        wr_reg(tmo_pkg::ADDR_T2_ENABLE, 32'h00000040);
        settle();
        check({30'h0, t1_irq, t2_irq}, 32'h1, "second irq");
        wr_reg(tmo_pkg::ADDR_T1_PENDING, 32'h0000005f);
        wr_reg(tmo_pkg::ADDR_T2_PENDING, 32'h0000005f);
        rd_chk(tmo_pkg::ADDR_T2_PENDING, 32'h0);
        wr_reg(tmo_pkg::ADDR_T1_ENABLE, 32'h0);
        wr_reg(tmo_pkg::ADDR_T2_ENABLE, 32'h0);
        $display("test pending finished");
    endtask

    task automatic test_missed();
        pulse(7'h02, 7'h10);
        rd_chk(tmo_pkg::ADDR_T1_MISSED, 32'h0);
        pulse(7'h02, 7'h10);
        rd_chk(tmo_pkg::ADDR_T1_MISSED, 32'h00000200);
        rd_chk(tmo_pkg::ADDR_T2_MISSED, 32'h00001000);
        rd_chk(tmo_pkg::ADDR_IRQ_STATUS, 32'h00000003);
        check({31'h0, irq}, 32'h0, "masked irq");
        wr_reg(tmo_pkg::ADDR_IRQ_MASK, 32'h00000001);
        settle();
        check({31'h0, irq}, 32'h1, "unmasked irq");
        wr_reg(tmo_pkg::ADDR_IRQ_STATUS, 32'h00000001);
        settle();
        check({31'h0, irq}, 32'h0, "irq after status clear");
        rd_chk(tmo_pkg::ADDR_IRQ_STATUS, 32'h00000002);
        wr_reg(tmo_pkg::ADDR_IRQ_MASK, 32'h00000003);
        settle();
        check({31'h0, irq}, 32'h1, "second status bit");
        rd_chk(tmo_pkg::ADDR_IRQ_MASK, 32'h00000003);
        wr_reg(tmo_pkg::ADDR_IRQ_STATUS, 32'h00000002);
        settle();
        check({31'h0, irq}, 32'h0, "irq after second clear");
        wr_reg(tmo_pkg::ADDR_T1_MISSED, 32'h00001e7f);
        rd_chk(tmo_pkg::ADDR_T1_MISSED, 32'h00001e00);
        wr_reg(tmo_pkg::ADDR_T2_MISSED, 32'h0);
        rd_chk(tmo_pkg::ADDR_T2_MISSED, 32'h0);
        $display("test missed finished");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // whole run is a few hundred cycles; this leaves ample margin
    initial begin
        #200us;
        fail_count++;
        print_verdict();
    end

    initial begin
        nrst = 1'b0;
        {wr, rd, cal_clk, ref_clk, pin1, pin2, gate1, gate2} = 8'h00;
        addr = 32'h0;
        wdata = 32'h0;
        ev1 = 7'h00;
        ev2 = 7'h00;
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        test_reset();
        test_options();
        test_trigger();
        test_pending();
        test_missed();
        print_verdict();
    end
endmodule
`default_nettype wire
